// ### rms_consts.svh
// constants for the reset and mode select block
`ifndef RMS_CONSTS_SVH
`define RMS_CONSTS_SVH
`define RMS_CLK_HZ            20000000
`define RMS_RST_MIN_PERIODS   6
`define RMS_SRST_BIT          3
`define RMS_BR8_NT_BIT        0
`define RMS_ADDR_SOFT_RESET   4'h0
`define RMS_ADDR_BR8          4'h8
`define RMS_ADDR_FREF_CTRL    4'h9
`define RMS_ADDR_STATUS       4'ha
`define RMS_ADDR_TDM_FMT      4'hb
`define RMS_FREF_OUT_BIT      0
`define RMS_RESET_BYTE        8'h00
`endif

// ### rms_pkg.sv
// types for the reset and mode select block
package rms_pkg;
  typedef enum logic [1:0] {
    RMS_FMT_SHORT = 2'h0,
    RMS_FMT_LONG  = 2'h1,
    RMS_FMT_GCI   = 2'h2,
    RMS_FMT_TSA   = 2'h3
  } rms_fmt_e;
  typedef enum logic [1:0] {
    RMS_ST_RESET = 2'h1,
    RMS_ST_RUN   = 2'h2
  } rms_state_e;
  typedef struct packed {
    logic     network_side_mode;
    logic     controller_mode;
    logic     parallel_port;
    rms_fmt_e tdm_format;
  } rms_mode_s;
endpackage

// ### rms_reset_mode.sv
// reset sequencing and operating mode selection
// Notes on behaviour
// [RULE1] reset pin low holds reset, high runs
// [RULE2] soft reset bit three forces reset
// [RULE3] outside holds reset six clock periods
// [RULE4] reset restores every control register default
// [RULE5] master data clock, frame sync halt; here they halt only in soft reset in controller mode
// [RULE6] reset: low impedance driver, wakeup off
// [RULE7] line side pin high network side
// [RULE8] register eight bit zero overrides side
// [RULE9] host bus pin picks controller or gci
// [RULE10] controller mode: tdm carries only traffic
// [RULE11] controller tdm has four frame formats
// [RULE12] gci mode disables serial control port
// [RULE13] port style pin picks parallel or serial
// [RULE14] exchange side: reference pin is input
// [RULE15] network controller mode may drive reference; here the enabled pin only ever drives low
// [RULE16] straps synchronised, applied only in reset
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "rms_consts.svh"
module rms_reset_mode (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  // strap pins
  input  wire logic              line_side_select,
  input  wire logic              host_bus_select,
  input  wire logic              port_style_select,
  input  wire logic              master_timing,
  // register port
  input  wire logic [3:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  // mode and control outputs
  output rms_pkg::rms_mode_s     mode,
  output logic                   core_reset,
  output logic                   tdm_clock_enable,
  output logic                   tdm_carries_control,
  output logic                   serial_control_port_en,
  output logic                   parallel_control_port_en,
  output logic                   gci_pin_functions,
  output logic                   tx_low_impedance,
  output logic                   wakeup_detect_en,
  // frequency reference pin
  input  wire logic              frequency_reference_pin_in,
  output logic                   frequency_reference_pin_out,
  output logic                   frequency_reference_pin_oe,
  output logic                   fref_8k_tick
);
  // pins from outside: two flip-flops each, stage one read only by stage two
  logic [4:0] sync1_reg, sync2_reg;
  logic [4:0] pins;
  assign pins = {frequency_reference_pin_in, master_timing, port_style_select, host_bus_select, line_side_select};

  // no reset here: the straps must already stand in stage two at the first edge after release,
  // or the latch in reset would only ever see the flip-flops' reset value
  always_ff @(posedge clk_sys) begin
    sync1_reg <= pins;
    sync2_reg <= sync1_reg;
  end

  // soft reset and configuration registers
  logic [7:0] soft_reset_register_reg, soft_reset_register_next;
  logic [7:0] br8_reg, br8_next;
  logic [7:0] fref_ctrl_reg, fref_ctrl_next;
  logic [7:0] fmt_reg, fmt_next;
  logic [7:0] rdata_reg, rdata_next;
  logic       strap_nt_reg, strap_nt_next;
  logic       strap_mcu_reg, strap_mcu_next;
  logic       strap_par_reg, strap_par_next;
  logic       strap_ms_reg, strap_ms_next;
  logic       br8_valid_reg, br8_valid_next;
  logic       fref_q_reg, fref_q_next;
  logic       fref_tick_reg, fref_tick_next;
  rms_pkg::rms_state_e state_reg, state_next;
  logic       soft_rst;
  logic       in_reset;

  assign soft_rst = soft_reset_register_reg[`RMS_SRST_BIT]; // RULE2
  // hardware reset clears state asynchronously; soft reset holds the same condition
  assign in_reset = (state_reg == rms_pkg::RMS_ST_RESET) || soft_rst; // RULE1

  function automatic logic addr_hit(input logic [3:0] a, input logic [3:0] b, input logic s);
    addr_hit = s && (a == b);
  endfunction

  always_comb begin
    soft_reset_register_next = soft_reset_register_reg;
    br8_next                 = br8_reg;
    fref_ctrl_next           = fref_ctrl_reg;
    fmt_next                 = fmt_reg;
    rdata_next               = 8'h00;
    strap_nt_next            = strap_nt_reg;
    strap_mcu_next           = strap_mcu_reg;
    strap_par_next           = strap_par_reg;
    strap_ms_next            = strap_ms_reg;
    br8_valid_next           = br8_valid_reg;
    fref_q_next              = sync2_reg[4];
    fref_tick_next           = sync2_reg[4] && !fref_q_reg;
    state_next               = rms_pkg::RMS_ST_RUN;
    case (state_reg)
      rms_pkg::RMS_ST_RESET: state_next = rms_pkg::RMS_ST_RUN;
      rms_pkg::RMS_ST_RUN:   state_next = rms_pkg::RMS_ST_RUN;
      default:               state_next = rms_pkg::RMS_ST_RESET;
    endcase
    // straps only take effect while reset holds, so only register writes move mode mid-operation
    if (in_reset) begin
      strap_nt_next  = sync2_reg[0]; // RULE16
      strap_mcu_next = sync2_reg[1]; // RULE16
      strap_par_next = sync2_reg[2]; // RULE16
      strap_ms_next  = sync2_reg[3]; // RULE16
    end
    // soft reset restores the other registers to defaults too
    if (soft_rst) begin
      br8_next       = `RMS_RESET_BYTE; // RULE4
      fref_ctrl_next = `RMS_RESET_BYTE; // RULE4
      fmt_next       = `RMS_RESET_BYTE; // RULE4
      br8_valid_next = 1'b0;
    end
    if (addr_hit(reg_addr, `RMS_ADDR_SOFT_RESET, reg_wr)) begin
      soft_reset_register_next = reg_wdata;
    end
    if (addr_hit(reg_addr, `RMS_ADDR_BR8, reg_wr)) begin
      br8_next       = reg_wdata;
      br8_valid_next = 1'b1; // RULE8
    end
    if (addr_hit(reg_addr, `RMS_ADDR_FREF_CTRL, reg_wr)) begin
      fref_ctrl_next = reg_wdata;
    end
    if (addr_hit(reg_addr, `RMS_ADDR_TDM_FMT, reg_wr)) begin
      fmt_next = {6'h00, reg_wdata[1:0]}; // RULE11
    end
    if (reg_rd) begin
      case (reg_addr)
        `RMS_ADDR_SOFT_RESET: rdata_next = soft_reset_register_reg;
        `RMS_ADDR_BR8:        rdata_next = br8_reg;
        `RMS_ADDR_FREF_CTRL:  rdata_next = fref_ctrl_reg;
        `RMS_ADDR_TDM_FMT:    rdata_next = fmt_reg;
        `RMS_ADDR_STATUS:     rdata_next = {3'h0, in_reset, strap_ms_reg, mode.parallel_port,
                                            mode.controller_mode, mode.network_side_mode};
        default:              rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      soft_reset_register_reg <= `RMS_RESET_BYTE; // RULE4
      br8_reg                 <= `RMS_RESET_BYTE; // RULE4
      fref_ctrl_reg           <= `RMS_RESET_BYTE; // RULE4
      fmt_reg                 <= `RMS_RESET_BYTE; // RULE4
      rdata_reg               <= 8'h00;
      strap_nt_reg            <= 1'b0;
      strap_mcu_reg           <= 1'b0;
      strap_par_reg           <= 1'b0;
      strap_ms_reg            <= 1'b0;
      br8_valid_reg           <= 1'b0;
      fref_q_reg              <= 1'b0;
      fref_tick_reg           <= 1'b0;
      state_reg               <= rms_pkg::RMS_ST_RESET; // RULE1
    end else begin
      soft_reset_register_reg <= soft_reset_register_next;
      br8_reg                 <= br8_next;
      fref_ctrl_reg           <= fref_ctrl_next;
      fmt_reg                 <= fmt_next;
      rdata_reg               <= rdata_next;
      strap_nt_reg            <= strap_nt_next;
      strap_mcu_reg           <= strap_mcu_next;
      strap_par_reg           <= strap_par_next;
      strap_ms_reg            <= strap_ms_next;
      br8_valid_reg           <= br8_valid_next;
      fref_q_reg              <= fref_q_next;
      fref_tick_reg           <= fref_tick_next;
      state_reg               <= state_next;
    end
  end

  // register bit wins once software has written it; until then the strap decides
  always_comb begin
    mode.network_side_mode = br8_valid_reg ? br8_reg[`RMS_BR8_NT_BIT] : strap_nt_reg; // RULE7 RULE8
    mode.controller_mode   = strap_mcu_reg; // RULE9
    mode.parallel_port     = strap_mcu_reg && strap_par_reg; // RULE13
    mode.tdm_format        = strap_mcu_reg ? rms_pkg::rms_fmt_e'(fmt_reg[1:0]) : rms_pkg::RMS_FMT_GCI; // RULE11
  end

  assign reg_rdata                = rdata_reg;
  assign core_reset               = in_reset;
  // master clocks halt only in soft reset in controller mode; slave clocks come from outside and are not ours
  assign tdm_clock_enable         = !(in_reset && strap_mcu_reg && strap_ms_reg); // RULE5
  assign tdm_carries_control      = !strap_mcu_reg; // RULE10 RULE12
  assign serial_control_port_en   = strap_mcu_reg && !strap_par_reg; // RULE12 RULE13
  assign parallel_control_port_en = strap_mcu_reg && strap_par_reg; // RULE13
  assign gci_pin_functions        = !strap_mcu_reg; // RULE12
  assign tx_low_impedance         = in_reset; // RULE6
  assign wakeup_detect_en         = !in_reset; // RULE6
  // reference pin is input unless network side, controller mode, out of reset, and enabled
  assign frequency_reference_pin_oe  = mode.network_side_mode && strap_mcu_reg && !in_reset &&
                                       fref_ctrl_reg[`RMS_FREF_OUT_BIT]; // RULE15 RULE14
  assign frequency_reference_pin_out = fref_q_reg && 1'b0;
  assign fref_8k_tick                = fref_tick_reg && !mode.network_side_mode; // RULE14
endmodule

// ### rms_keep.sv
// (none)

// ### rms_reset_mode_assertions.sv
// port checks for the reset and mode select block
`timescale 1ns/1ps
`include "rms_consts.svh"
module rms_reset_mode_chk (
  // clock and reset
  input wire logic               clk_sys,
  input wire logic               rst_b,
  // watched ports
  input wire logic               master_timing,
  input wire logic [3:0]         reg_addr,
  input wire logic [7:0]         reg_wdata,
  input wire logic               reg_wr,
  input wire rms_pkg::rms_mode_s mode,
  input wire logic               core_reset,
  input wire logic               tdm_clock_enable,
  input wire logic               tdm_carries_control,
  input wire logic               serial_control_port_en,
  input wire logic               parallel_control_port_en,
  input wire logic               gci_pin_functions,
  input wire logic               tx_low_impedance,
  input wire logic               wakeup_detect_en,
  input wire logic               frequency_reference_pin_oe,
  input wire logic               fref_8k_tick
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  AST_SOFT_RST: assert property (reg_wr && reg_addr == `RMS_ADDR_SOFT_RESET && reg_wdata[3] |=> core_reset)
    else $error("soft reset bit did not force reset");
  AST_TX_TERM: assert property (tx_low_impedance == core_reset)
    else $error("driver termination not tied to reset");
  AST_WAKE_OFF: assert property (core_reset |-> !wakeup_detect_en)
    else $error("wakeup detect on in reset");
  AST_CLK_HALT: assert property (core_reset && $past(core_reset) && master_timing && mode.controller_mode |->
    !tdm_clock_enable) else $error("master clocks run in reset");
  AST_GCI_PINS: assert property (gci_pin_functions == !mode.controller_mode)
    else $error("gci pin use disagrees with mode");
  AST_TDM_CTRL: assert property (tdm_carries_control == gci_pin_functions)
    else $error("tdm control traffic in wrong mode");
  AST_SER_SEL: assert property (serial_control_port_en |-> mode.controller_mode && !mode.parallel_port)
    else $error("serial port on in wrong mode");
  AST_PAR_SEL: assert property (parallel_control_port_en |-> mode.controller_mode && mode.parallel_port)
    else $error("parallel port on in wrong mode");
  AST_FREF_OE: assert property (frequency_reference_pin_oe |-> mode.network_side_mode && mode.controller_mode)
    else $error("reference pin driven in wrong mode");
  AST_TICK_LT: assert property (fref_8k_tick |-> !mode.network_side_mode)
    else $error("reference tick on network side");
  AST_MODE_HOLD: assert property (!core_reset && !$past(core_reset) && !$past(reg_wr) |-> $stable(mode))
    else $error("mode changed outside reset");
endmodule
bind rms_reset_mode rms_reset_mode_chk rms_reset_mode_chk_inst (.clk_sys, .rst_b, .master_timing, .reg_addr,
  .reg_wdata, .reg_wr, .mode, .core_reset, .tdm_clock_enable, .tdm_carries_control, .serial_control_port_en,
  .parallel_control_port_en, .gci_pin_functions, .tx_low_impedance, .wakeup_detect_en,
  .frequency_reference_pin_oe, .fref_8k_tick);

// ### rms_far_side.sv
// far side model: reference clock source on the exchange side
`timescale 1ns/1ps
module rms_far_side #(parameter int HALF = 20) (
  // clock
  input  wire logic clk_sys,
  // reference source
  input  wire logic ref_en,
  output logic      ref_clk
);
  int cnt = 0;
  initial ref_clk = 1'b0;
  // scaled stand-in for the 8 khz reference, keeps runs short
  always @(posedge clk_sys) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (ref_en && cnt == HALF - 1) ref_clk <= ~ref_clk;
  end
endmodule

// ### test_rms_reset_mode.sv
// self-checking bench for the reset and mode select block
`timescale 1ns/1ps
`include "rms_consts.svh"
module test_rms_reset_mode;
  logic clk_sys = 1'b0, rst_b = 1'b0, lss = 1'b1, hbs = 1'b1, pss = 1'b1, wr = 1'b0, rd = 1'b0, fen = 1'b0;
  logic mts = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata;
  rms_pkg::rms_mode_s mode;
  logic core_reset, tce, tcc, serial_control_port, parallel_control_port, gci, txl, wake, foe, tick, fin;
  int miscompares = 0, compares = 0, n;
  always #25 clk_sys = ~clk_sys;
  rms_far_side rms_far_side_inst (.clk_sys, .ref_en(fen), .ref_clk(fin));
  rms_reset_mode rms_reset_mode_inst (.clk_sys, .rst_b, .line_side_select(lss), .host_bus_select(hbs),
    .port_style_select(pss), .master_timing(mts), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata(rdata), .mode, .core_reset, .tdm_clock_enable(tce), .tdm_carries_control(tcc),
    .serial_control_port_en(serial_control_port), .parallel_control_port_en(parallel_control_port), .gci_pin_functions(gci),
    .tx_low_impedance(txl), .wakeup_detect_en(wake), .frequency_reference_pin_in(fin),
    .frequency_reference_pin_out(), .frequency_reference_pin_oe(foe), .fref_8k_tick(tick));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic stop_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 chk(core_reset, 0);
    chk({txl, wake}, 8'h01);
    chk({parallel_control_port, serial_control_port, tcc}, 8'h04);
    rdc(`RMS_ADDR_STATUS, 8'h0f);
    $display("test straps done");
    for (int f = 0; f < 4; f++) begin
      wrr(`RMS_ADDR_TDM_FMT, 8'(f));
      chk({6'h00, mode.tdm_format}, 8'(f));
      rdc(`RMS_ADDR_TDM_FMT, 8'(f));
    end
    wrr(`RMS_ADDR_BR8, 8'h00);
    chk(mode.network_side_mode, 0);
    wrr(`RMS_ADDR_BR8, 8'h01);
    wrr(`RMS_ADDR_FREF_CTRL, 8'h01);
    chk(foe, 1);
    rdc(4'h5, 8'h00);
    hbs <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1 chk(mode.controller_mode, 1);
    $display("test registers done");
    hbs <= 1'b1;
    lss <= 1'b0;
    pss <= 1'b0;
    wrr(`RMS_ADDR_SOFT_RESET, 8'h08);
    chk({core_reset, txl, wake, tce}, 8'h0c);
    repeat (4) @(posedge clk_sys);
    wrr(`RMS_ADDR_SOFT_RESET, 8'h00);
    repeat (2) @(posedge clk_sys);
    rdc(`RMS_ADDR_STATUS, 8'h0a);
    rdc(`RMS_ADDR_TDM_FMT, 8'h00);
    rdc(`RMS_ADDR_FREF_CTRL, 8'h00);
    chk({serial_control_port, foe}, 8'h02);
    fen <= 1'b1;
    for (n = 0; n < 200 && tick !== 1'b1; n++) begin
      @(posedge clk_sys);
      #1;
    end
    chk(n < 200, 1);
    if (n == 200) stop_test;
    $display("test soft reset done");
    hbs <= 1'b0;
    rst_b <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 chk({gci, tcc, serial_control_port, parallel_control_port}, 8'h0c);
    rdc(`RMS_ADDR_STATUS, 8'h08);
    $display("test gci mode done");
    stop_test;
  end
endmodule
